// File: src/apcs_regs.svh
// Purpose: constants for the pair conversion sequencer, both ends
// Assumes: 100 MHz system clock, conversion clock made by a divider enable
// Notes: configuration bit positions are those of the 32-bit config word
`ifndef APCS_REGS_SVH
`define APCS_REGS_SVH
`define APCS_CFG_WIDTH 32
`define APCS_POS_REFDAC_LO 0
`define APCS_POS_REFDAC_HI 9
`define APCS_POS_REF_MODE 13
`define APCS_POS_REF_ENABLE 15
`define APCS_POS_RANGE_A 16
`define APCS_POS_STATUS_POL 26
`define APCS_POS_STATUS_FUNC 27
`define APCS_POS_CLK_SRC 29
`define APCS_CFG_RESET 32'h00000000
`define APCS_CONV_CYCLES 5'h13
`define APCS_SLEEP_CYCLES 5'h1A
`define APCS_INTERNAL_CONV_CLOCK_DIV 4'h8
`define APCS_REF_2V5_MV 13'h09C4
`define APCS_REF_3V0_MV 13'h0BB8
`define APCS_DAC_MIN_MV 13'h01F4
`define APCS_NUM_PAIRS 4
`endif

// File: src/apcs_pkg.sv
// Purpose: shared types for the pair conversion sequencer
// Assumes: constants come from apcs_regs.svh
// Notes: one-hot state codes written out
package apcs_pkg;
  typedef enum logic [2:0] {
    APCS_IDLE = 3'h1,
    APCS_HOLD = 3'h2,
    APCS_CONV = 3'h4
  } apcs_pair_state_e;
  typedef logic [3:0] apcs_pair_t;
  typedef logic [9:0] apcs_dac_t;
endpackage

// File: src/apcs_if.sv
// Purpose: pins between the converter device and its host controller
// Assumes: one system clock on both ends
// Notes: the status pin is a plain output of the device
`timescale 1ns/1ps
`default_nettype none
interface apcs_if (
  input wire logic clock,
  input wire logic rst
);
  logic [3:0] pair_sample_strobe; // bit 0 is the master strobe
  logic external_conv_clock;
  logic auto_sleep_pin;
  logic config_source_pin;
  logic range_pin;
  logic [31:0] config_word;
  logic config_load;
  logic read_access;
  logic status_pin;
  modport device (
    input pair_sample_strobe, external_conv_clock, auto_sleep_pin, config_source_pin,
    input range_pin, config_word, config_load, read_access,
    output status_pin
  );
  modport host (
    output pair_sample_strobe, external_conv_clock, auto_sleep_pin, config_source_pin,
    output range_pin, config_word, config_load, read_access,
    input status_pin
  );
endinterface
`default_nettype wire

// File: src/apcs_pair_conv.sv
// Purpose: one channel pair: hold, pre-charge and convert
// Assumes: start and conv_tick are single-cycle pulses in the system clock
// Notes: a start during an ongoing conversion is ignored
`timescale 1ns/1ps
`default_nettype none
`include "apcs_regs.svh"
module apcs_pair_conv
  import apcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic conv_tick,
  input wire logic [4:0] length,
  output logic held,
  output logic converting,
  output logic done
);
  apcs_pair_state_e state_r;
  logic [4:0] count_r;

  ////////////////////////////////////////////////////////////////////////////
  // sequence: hold on strobe, convert from next conversion clock edge
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= APCS_IDLE;
      count_r <= 5'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        APCS_IDLE: begin
          if (start) begin
            state_r <= APCS_HOLD;
          end
        end
        APCS_HOLD: begin
          if (conv_tick) begin
            state_r <= APCS_CONV;
            count_r <= 5'h01; // first cycle is the pre-charge
          end
        end
        APCS_CONV: begin
          if (conv_tick) begin
            if (count_r >= length) begin
              state_r <= APCS_IDLE;
              done <= 1'b1;
            end else begin
              count_r <= count_r + 5'h01;
            end
          end
        end
        default: state_r <= APCS_IDLE;
      endcase
    end
  end

  assign held = (state_r != APCS_IDLE);
  assign converting = held;
endmodule
`default_nettype wire

// File: src/apcs_device.sv
// Purpose: conversion control and status of the eight-channel pair converter
// Assumes: strobes and external clock arrive asynchronously on pins
// Notes: analog parts are modelled as settings on output ports only
`timescale 1ns/1ps
`default_nettype none
`include "apcs_regs.svh"
module apcs_device
  import apcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  apcs_if.device link,
  output logic range_4x,
  output logic ref_3v_mode,
  output logic ref_enable,
  output logic [12:0] ref_millivolts,
  output logic [2:0] next_out_channel,
  output logic [3:0] pair_held
);
  logic [31:0] cfg_r;
  logic [3:0] strb_s1_r, strb_s2_r, strb_d_r;
  logic [1:0] external_conv_clock_s_r;
  logic external_conv_clock_d_r, sleep_s1_r, sleep_s2_r, rng_s1_r, rng_s2_r;
  logic [3:0] cdiv_r;
  logic [3:0] rise, conv_busy, done;
  logic internal_conv_clock_tick, external_conv_clock_tick, conv_tick, ext_sel, busy, busy_d_r, range_latch_r, ready_r;
  logic [4:0] conv_len;
  logic [22:0] dac_prod;

  ////////////////////////////////////////////////////////////////////////////
  // configuration word from the host; internal reference off after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r <= `APCS_CFG_RESET;
    end else if (link.config_load) begin
      cfg_r <= link.config_word;
    end
  end

  // pin synchronisers: first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      strb_s1_r <= 4'h0;
      strb_s2_r <= 4'h0;
      strb_d_r <= 4'h0;
      external_conv_clock_s_r <= 2'h0;
      external_conv_clock_d_r <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      rng_s1_r <= 1'b0;
      rng_s2_r <= 1'b0;
    end else begin
      strb_s1_r <= link.pair_sample_strobe;
      strb_s2_r <= strb_s1_r;
      strb_d_r <= strb_s2_r;
      external_conv_clock_s_r <= {external_conv_clock_s_r[0], link.external_conv_clock};
      external_conv_clock_d_r <= external_conv_clock_s_r[1];
      sleep_s1_r <= link.auto_sleep_pin;
      sleep_s2_r <= sleep_s1_r;
      rng_s1_r <= link.range_pin;
      rng_s2_r <= rng_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal conversion clock as a divider enable
  always_ff @(posedge clock) begin
    if (rst) begin
      cdiv_r <= 4'h0;
    end else if (cdiv_r == `APCS_INTERNAL_CONV_CLOCK_DIV - 4'h1) begin
      cdiv_r <= 4'h0;
    end else begin
      cdiv_r <= cdiv_r + 4'h1;
    end
  end

  // external clock only selectable in software mode; it may stop between frames
  assign ext_sel = link.config_source_pin & cfg_r[`APCS_POS_CLK_SRC];
  assign internal_conv_clock_tick = (cdiv_r == 4'h0);
  assign external_conv_clock_tick = external_conv_clock_s_r[1] & ~external_conv_clock_d_r;
  assign conv_tick = ext_sel ? external_conv_clock_tick : internal_conv_clock_tick;
  // strobe phase against the free internal tick gives 19 or 20 cycles in all, 26 or 27 with auto sleep
  assign conv_len = sleep_s2_r ? `APCS_SLEEP_CYCLES : `APCS_CONV_CYCLES;
  assign rise = strb_s2_r & ~strb_d_r;

  genvar gi;
  generate
    for (gi = 0; gi < `APCS_NUM_PAIRS; gi = gi + 1) begin : g_pair
      apcs_pair_conv u_pair (
        .clock(clock),
        .rst(rst),
        .start(rise[gi]),
        .conv_tick(conv_tick),
        .length(conv_len),
        .held(pair_held[gi]),
        .converting(conv_busy[gi]),
        .done(done[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // busy: any pair converting; a finished pair drops busy for one conversion cycle
  logic gap_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      gap_r <= 1'b0;
    end else if (|done) begin
      gap_r <= 1'b1;
    end else if (conv_tick | (|rise)) begin
      gap_r <= 1'b0;
    end
  end
  assign busy = ((|conv_busy) | (|rise)) & ~(gap_r & ~(|rise));

  // range pin caught on the falling edge of busy, only while the status polarity bit is clear
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_d_r <= 1'b0;
      range_latch_r <= 1'b0;
    end else begin
      busy_d_r <= busy;
      if (busy_d_r & ~busy & ~cfg_r[`APCS_POS_STATUS_POL]) begin
        range_latch_r <= rng_s2_r;
      end
    end
  end

  // data ready: set on load wins over clear on read
  always_ff @(posedge clock) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else if (|done) begin
      ready_r <= 1'b1;
    end else if (link.read_access) begin
      ready_r <= 1'b0;
    end
  end

  // output channel pointer: master strobe restarts at A0, reads advance
  always_ff @(posedge clock) begin
    if (rst) begin
      next_out_channel <= 3'h0;
    end else if (rise[0]) begin
      next_out_channel <= 3'h0;
    end else if (link.read_access) begin
      next_out_channel <= next_out_channel + 3'h1;
    end
  end

  assign link.status_pin = (cfg_r[`APCS_POS_STATUS_FUNC] ? ready_r : busy)
                           ^ cfg_r[`APCS_POS_STATUS_POL];

  ////////////////////////////////////////////////////////////////////////////
  // analog settings; software mode ignores the range pin
  assign range_4x = link.config_source_pin ? cfg_r[`APCS_POS_RANGE_A] : range_latch_r;
  assign ref_3v_mode = cfg_r[`APCS_POS_REF_MODE];
  assign ref_enable = cfg_r[`APCS_POS_REF_ENABLE];
  assign dac_prod = (ref_3v_mode ? `APCS_REF_3V0_MV : `APCS_REF_2V5_MV)
                    * ({3'h0, cfg_r[`APCS_POS_REFDAC_HI:`APCS_POS_REFDAC_LO]} + 13'h0001);
  assign ref_millivolts = dac_prod[22:10];
endmodule
`default_nettype wire

// File: src/apcs_host.sv
// Purpose: host controller end: issues pair strobes, config and reads
// Assumes: user requests are single-cycle pulses
// Notes: external conversion clock made by a divider and driven out
`timescale 1ns/1ps
`default_nettype none
`include "apcs_regs.svh"
module apcs_host
  import apcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  apcs_if.host link,
  input wire logic [3:0] start_req,
  input wire logic software_mode,
  input wire logic sleep_mode,
  input wire logic range_sel,
  input wire logic [31:0] cfg_data,
  input wire logic cfg_write,
  input wire logic read_req,
  output logic [3:0] pair_pending,
  output logic status_seen
);
  logic [3:0] xdiv_r, strobe_r, pend_r;
  logic external_conv_clock_r, st_s1_r, st_s2_r, space_r;

  // external conversion clock, half period of the divider
  always_ff @(posedge clock) begin
    if (rst) begin
      xdiv_r <= 4'h0;
      external_conv_clock_r <= 1'b0;
    end else if (xdiv_r == (`APCS_INTERNAL_CONV_CLOCK_DIV >> 1) - 4'h1) begin
      xdiv_r <= 4'h0;
      external_conv_clock_r <= ~external_conv_clock_r;
    end else begin
      xdiv_r <= xdiv_r + 4'h1;
    end
  end

  // strobes issued while external_conv_clock is high, at least one external_conv_clock period apart
  always_ff @(posedge clock) begin
    if (rst) begin
      strobe_r <= 4'h0;
      pend_r <= 4'h0;
      space_r <= 1'b0;
    end else begin
      strobe_r <= 4'h0;
      // requests are one-cycle pulses, so they are caught in every phase of external_conv_clock
      if (external_conv_clock_r & (xdiv_r == 4'h0) & (|pend_r) & ~space_r) begin
        strobe_r <= pend_r;
        pend_r <= start_req;
        space_r <= 1'b1;
      end else begin
        pend_r <= pend_r | start_req;
        if (~external_conv_clock_r) begin
          space_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_s1_r <= 1'b0;
      st_s2_r <= 1'b0;
    end else begin
      st_s1_r <= link.status_pin;
      st_s2_r <= st_s1_r;
    end
  end

  assign link.pair_sample_strobe = strobe_r;
  assign link.external_conv_clock = external_conv_clock_r;
  assign link.auto_sleep_pin = sleep_mode;
  assign link.config_source_pin = software_mode;
  assign link.range_pin = range_sel;
  assign link.config_word = cfg_data;
  assign link.config_load = cfg_write;
  assign link.read_access = read_req;
  assign pair_pending = pend_r;
  assign status_seen = st_s2_r;
endmodule
`default_nettype wire

// File: verification/apcs_chk.sv
// Purpose: status pin checks against strobes, reads and config
// Assumes: config mirrored on config_load, tick every 8 clocks
// Notes: length checks skip external clock and overlapped pairs
`timescale 1ns/1ps
`default_nettype none
module apcs_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] pair_sample_strobe,
  input wire logic external_conv_clock,
  input wire logic auto_sleep_pin,
  input wire logic config_source_pin,
  input wire logic range_pin,
  input wire logic [31:0] config_word,
  input wire logic config_load,
  input wire logic read_access,
  input wire logic status_pin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] cfg_r;
  logic [3:0] strb_r;
  logic [8:0] quiet_r;
  logic [8:0] hi_r;
  logic [2:0] nstrb_r;
  logic lvl_r;
  wire logic lvl = status_pin ^ cfg_r[26];
  wire logic busy_m = !cfg_r[27];
  wire logic rise = |(pair_sample_strobe & ~strb_r);
  ////////////////////////////////////////////////////////////////
  // config mirror, loaded on the same edge as the device
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r <= 32'h00000000;
    end else if (config_load) begin
      cfg_r <= config_word;
    end
  end
  // quiet saturates so an idle pin can be judged without knowing pair state
  always_ff @(posedge clock) begin
    if (rst) begin
      strb_r <= 4'h0;
      quiet_r <= 9'h000;
      hi_r <= 9'h000;
      nstrb_r <= 3'h0;
      lvl_r <= 1'b0;
    end else begin
      strb_r <= pair_sample_strobe;
      quiet_r <= rise ? 9'h000 : (quiet_r == 9'h1FF ? quiet_r : quiet_r + 9'h001);
      hi_r <= lvl ? hi_r + 9'h001 : 9'h000;
      nstrb_r <= (lvl_r && !lvl) ? {2'h0, rise} : nstrb_r + {2'h0, rise};
      lvl_r <= lvl;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_one_end;
    busy_m && !cfg_r[29] && $fell(lvl) && nstrb_r == 3'h1;
  endsequence
  a_busy_rise: assert property (busy_m && rise && quiet_r == 9'h1FF |-> ##[1:4] lvl)
    else $error("busy late after strobe");
  a_conv_min: assert property (s_one_end |-> hi_r >= 9'h090)
    else $error("conversion too short");
  a_conv_max: assert property (s_one_end and !auto_sleep_pin |-> hi_r <= 9'h0AC)
    else $error("conversion too long");
  a_sleep_max: assert property (s_one_end |-> hi_r <= 9'h0E8)
    else $error("sleep conversion too long");
  a_busy_dip: assert property (busy_m && $fell(lvl) |-> !lvl [*6])
    else $error("busy low shorter than a tick");
  a_idle_level: assert property (busy_m && quiet_r == 9'h1FF |-> !lvl)
    else $error("busy seen while idle");
  a_ready_hold: assert property (!busy_m && lvl && !read_access && !config_load |=> lvl)
    else $error("ready dropped without read");
  a_ready_clear: assert property (!busy_m && read_access && quiet_r > 9'h0F0 |=> !lvl)
    else $error("ready kept after read");
endmodule
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench joining device and host ends
// Assumes: 100 MHz clock, status seen through the host's flops
// Notes: busy lengths are counted on the delayed status copy
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apcs_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] start_req = 4'h0;
  logic software_mode = 1'b0, sleep_mode = 1'b0, range_sel = 1'b0, cfg_write = 1'b0, read_req = 1'b0;
  logic [31:0] cfg_data = 32'h00000000;
  logic range_4x, ref_3v_mode, ref_enable, status_seen;
  logic [12:0] ref_millivolts;
  logic [2:0] next_out_channel;
  logic [3:0] pair_held, pair_pending;
  int errors = 0, n_compared = 0, cycles = 0;
  always #5 clock = ~clock;
  apcs_if apcs_if_inst (.clock, .rst);
  apcs_device apcs_device_inst (.clock, .rst, .link(apcs_if_inst.device), .range_4x, .ref_3v_mode,
    .ref_enable, .ref_millivolts, .next_out_channel, .pair_held);
  apcs_host apcs_host_inst (.clock, .rst, .link(apcs_if_inst.host), .start_req, .software_mode,
    .sleep_mode, .range_sel, .cfg_data, .cfg_write, .read_req, .pair_pending, .status_seen);
  apcs_chk apcs_chk_inst (.clock, .rst, .pair_sample_strobe(apcs_if_inst.pair_sample_strobe),
    .external_conv_clock(apcs_if_inst.external_conv_clock), .auto_sleep_pin(apcs_if_inst.auto_sleep_pin),
    .config_source_pin(apcs_if_inst.config_source_pin), .range_pin(apcs_if_inst.range_pin),
    .config_word(apcs_if_inst.config_word), .config_load(apcs_if_inst.config_load),
    .read_access(apcs_if_inst.read_access), .status_pin(apcs_if_inst.status_pin));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // drives start on a rising edge, samples on falling edges
  task automatic pulse(input logic [3:0] p, input logic rd);
    @(posedge clock);
    start_req <= p;
    read_req <= rd;
    @(posedge clock);
    start_req <= 4'h0;
    read_req <= 1'b0;
    repeat (6) @(negedge clock);
  endtask
  task automatic cfg(input logic [31:0] d);
    @(posedge clock);
    cfg_data <= d;
    cfg_write <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
    repeat (4) @(negedge clock);
  endtask
  // bounded waits; n is the busy length, s the snapshot at busy rise
  task automatic run_conv(input logic [3:0] p, output int n, output logic [4:0] s);
    pulse(p, 1'b0);
    // host waits for the high phase of external_conv_clock, then two sync stages each way
    n = 0;
    while (status_seen !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    s = {range_4x, pair_held};
    chk("busy up", 16'h0001, status_seen);
    n = 1;
    while (status_seen === 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    repeat (20) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_single();
    int n;
    logic [4:0] s;
    pulse(4'h0, 1'b1);
    chk("read advances", 16'h0001, next_out_channel);
    @(posedge clock);
    range_sel <= 1'b1;
    run_conv(4'h1, n, s);
    chk("pair held", 16'h0001, s[0]);
    chk("range before fall", 16'h0000, s[4]);
    chk("busy length", 16'h0001, n >= 144 && n <= 172);
    chk("first output", 16'h0000, next_out_channel);
    @(posedge clock);
    range_sel <= 1'b0;
    sleep_mode <= 1'b1;
    run_conv(4'h4, n, s);
    chk("sleep length", 16'h0001, n >= 144 && n <= 232);
    @(posedge clock);
    sleep_mode <= 1'b0;
    $display("t_single done");
  endtask
  task automatic t_seq();
    int falls;
    logic last;
    pulse(4'h1, 1'b0);
    // two ticks apart at least, or the two ends fall on neighbouring ticks and merge
    repeat (16) @(negedge clock);
    pulse(4'h8, 1'b0); // spaced above one tick
    falls = 0;
    last = 1'b1;
    repeat (400) begin
      @(negedge clock);
      if (last === 1'b1 && status_seen === 1'b0) falls++;
      last = status_seen;
    end
    chk("busy falls", 16'h0002, falls[15:0]);
    $display("t_seq done");
  endtask
  task automatic t_dac();
    logic [31:0] w [3] = '{32'h000081FF, 32'h000083FF, 32'h0000A1FF}; // all above 0.5 V
    logic [15:0] mv [3] = '{16'h04E2, 16'h09C4, 16'h05DC};
    logic r0;
    int n;
    logic [4:0] s;
    @(posedge clock);
    software_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cfg(w[i]);
      chk("ref mv", mv[i], {3'h0, ref_millivolts});
      chk("ref on", 16'h0001, ref_enable);
      chk("ref 3v", {15'h0000, w[i][13]}, ref_3v_mode);
    end
    r0 = range_4x;
    pulse(4'h0, 1'b0);
    @(posedge clock);
    range_sel <= ~range_sel;
    repeat (4) @(negedge clock);
    chk("range pin ignored", r0, range_4x);
    cfg(32'h00018000);
    chk("range bit", {15'h0000, ~r0}, range_4x);
    cfg(32'h20008000);
    run_conv(4'h1, n, s);
    chk("ext clock end", 16'h0001, n >= 144 && n <= 172);
    $display("t_dac done");
  endtask
  task automatic t_ready();
    int n;
    pulse(4'h0, 1'b1);
    cfg(32'h08008000);
    chk("ready idle", 16'h0000, status_seen);
    pulse(4'h2, 1'b0);
    for (n = 0; n < 260 && status_seen !== 1'b1; n++) @(negedge clock);
    repeat (100) @(negedge clock);
    chk("ready holds", 16'h0001, status_seen);
    pulse(4'h0, 1'b1);
    chk("ready cleared", 16'h0000, status_seen);
    cfg(32'h04008000);
    chk("inverted idle", 16'h0001, status_seen);
    cfg(32'h00000000);
    @(posedge clock);
    software_mode <= 1'b0;
    $display("t_ready done");
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard, a few times the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("ref off at reset", 16'h0000, ref_enable);
    t_single();
    t_seq();
    t_dac();
    t_ready();
    stop_test();
  end
endmodule
`default_nettype wire
